// >>> hw/adc_ctrl_pkg.sv
// Purpose: constants for converter input, reference and conversion control
// Assumes: 8-bit control registers on a plain strobe port
// Notes: offsets are word indices on the register port
package adc_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_CTRL_A = 4'h0;
  localparam logic [3:0] OFF_CTRL_B = 4'h1;
  localparam logic [3:0] OFF_CTRL_C = 4'h2;
  localparam logic [3:0] OFF_BANDGAP = 4'h3;
  localparam logic [3:0] OFF_PIN_FUNC = 4'h4;
  localparam logic [3:0] OFF_PULL_HIGH = 4'h5;
  localparam logic [3:0] OFF_PORT_DIR = 4'h6;
  localparam logic [3:0] OFF_INT_CTRL = 4'h7;
  // conv_ctrl_reg_a fields
  localparam int A_START_BIT = 7;
  localparam int A_BUSY_BIT = 6;
  localparam int A_EN_BIT = 5;
  localparam int A_FMT_BIT = 4;
  localparam int A_CHAN_LSB = 0;
  // conv_ctrl_reg_b fields
  localparam int B_SRC_LSB = 4;
  localparam int B_DIV_LSB = 0;
  // conv_ctrl_reg_c fields
  localparam int C_AMP_EN_BIT = 7;
  localparam int C_AMP_IN_BIT = 4;
  localparam int C_REF_LSB = 2;
  localparam int C_GAIN_LSB = 0;
  // interrupt control fields
  localparam int I_FLAG_BIT = 0;
  localparam int I_EN_BIT = 1;
  // reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing counts in conversion clock periods
  localparam int SAMPLE_PERIODS = 4;
  localparam int CONVERT_PERIODS = 12;
  localparam int TOTAL_PERIODS = SAMPLE_PERIODS + CONVERT_PERIODS;
  // reference source routing
  typedef enum logic [2:0]
  {
    REF_SUPPLY = 3'b001,
    REF_EXT_PIN = 3'b010,
    REF_AMP = 3'b100
  } ref_route_t;
  // converter input routing, one-hot
  typedef enum logic [4:0]
  {
    IN_EXT = 5'b00001,
    IN_SUPPLY = 5'b00010,
    IN_AMP = 5'b00100,
    IN_GND = 5'b01000,
    IN_FLOAT = 5'b10000
  } in_route_t;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;
endpackage : adc_ctrl_pkg

// >>> hw/conv_clk_div.sv
// Purpose: conversion clock tick from the system clock
// Assumes: one clock domain, synchronous reset copy
// Notes: tick is one cycle wide at the selected ratio
`timescale 1ns/1ps
`default_nettype none
module conv_clk_div #(
  parameter int DIV_W = 3
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic run_in,
  input wire logic [DIV_W-1:0] div_sel_in,
  // tick
  output logic tick_out
);
  localparam int CNT_W = (1 << DIV_W) - 1;
  initial
  begin
    if (DIV_W < 1 || DIV_W > 4)
    begin
      $error("conv_clk_div: DIV_W out of range");
    end
  end
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;
  assign limit = CNT_W'((1 << div_sel_in) - 1);
  // ***********************************************
  // divide by 1 to 128
  // ***********************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end
    // R19 power of two
    else if (cnt_r >= limit)
    begin
      cnt_r <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule : conv_clk_div
`default_nettype wire

// >>> hw/adc_ctrl.sv
// Purpose: reference, input routing and conversion control for one converter
// Assumes: 50 MHz clk_in, register port with read data one cycle later
// Notes: reference, input and channel switches appear as one-hot select outputs; gain and divider selects are binary codes
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - route reference from supply, pin, amplifier
// R2 - reference code 00 supply, 01 pin, 1x amplifier
// R3 - gain code picks 1, 1.667, 2.5, 3.333
// R4 - amplifier powered only while enabled
// R5 - bandgap feeds amplifier when selected
// R6 - internal reference disconnects external pin
// R7 - software readies bandgap and pin first
// R8 - analog pin disables other pin functions
// R9 - analog pin drops programmed pull-high
// R10 - analog pin overrides port direction
// R11 - source 0000 converts selected external channel
// R12 - internal source disconnects all external channels
// R13 - source code decodes to external, supply, amplifier, ground
// R14 - channel codes map, 1100 up floats
// R15 - start pulse high then low begins conversion
// R16 - busy set at start, cleared at end
// R17 - completion sets flag and raises interrupt
// R18 - conversion clock divides system clock
// R19 - divide codes give 1 to 128
// R20 - software keeps conversion period in range
// R21 - four sample plus twelve convert periods
// R22 - start on falling edge, ignored while busy
module adc_ctrl #(
  parameter int NUM_PINS = 8
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [adc_ctrl_pkg::DATA_W-1:0] rdata_out,
  // analog routing
  output logic [2:0] ref_route_out,
  output logic [1:0] ref_amp_gain_sel_out,
  output logic ref_amp_enable_out,
  output logic ref_amp_input_sel_out,
  output logic bandgap_enable_out,
  output logic ext_ref_pin_connect_out,
  output logic [4:0] in_route_out,
  output logic [1:0] div_factor_out,
  output logic [15:0] ext_channel_onehot_out,
  // converter core
  output logic conv_power_out,
  output logic sample_out,
  output logic convert_out,
  output logic done_out,
  output logic irq_out,
  // pin overrides
  output logic [NUM_PINS-1:0] pin_analog_out,
  output logic [NUM_PINS-1:0] pull_high_en_out,
  output logic [NUM_PINS-1:0] pin_dir_in_out
);
  import adc_ctrl_pkg::*;
  initial
  begin
    if (NUM_PINS < 1 || NUM_PINS > DATA_W)
    begin
      $error("adc_ctrl: NUM_PINS out of range");
    end
  end

  // ***********************************************
  // reset release
  // ***********************************************
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ***********************************************
  // control registers
  // ***********************************************
  logic start_r;
  logic conv_en_r;
  logic fmt_r;
  logic [3:0] ext_channel_sel_r;
  logic [3:0] input_source_sel_r;
  logic [2:0] conv_clock_div_sel_r;
  logic ref_amp_enable_r;
  logic ref_amp_input_sel_r;
  logic [1:0] ref_source_sel_r;
  logic [1:0] ref_amp_gain_sel_r;
  logic bandgap_en_r;
  logic [NUM_PINS-1:0] pin_func_r;
  logic [NUM_PINS-1:0] pull_high_r;
  logic [NUM_PINS-1:0] port_dir_r;
  logic int_en_r;
  logic irq_flag_r;
  logic busy_r;
  logic done_pulse;
  conv_state_t state_r;
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      start_r <= RST_CTRL_A[A_START_BIT];
      conv_en_r <= RST_CTRL_A[A_EN_BIT];
      fmt_r <= RST_CTRL_A[A_FMT_BIT];
      ext_channel_sel_r <= RST_CTRL_A[3:0];
      input_source_sel_r <= RST_CTRL_B[7:4];
      conv_clock_div_sel_r <= RST_CTRL_B[2:0];
      ref_amp_enable_r <= RST_CTRL_C[C_AMP_EN_BIT];
      ref_amp_input_sel_r <= RST_CTRL_C[C_AMP_IN_BIT];
      ref_source_sel_r <= RST_CTRL_C[3:2];
      ref_amp_gain_sel_r <= RST_CTRL_C[1:0];
      bandgap_en_r <= RST_BYTE[0];
      pin_func_r <= RST_BYTE[NUM_PINS-1:0];
      pull_high_r <= RST_BYTE[NUM_PINS-1:0];
      port_dir_r <= RST_BYTE[NUM_PINS-1:0];
      int_en_r <= RST_BYTE[I_EN_BIT];
    end
    else if (wr_in)
    begin
      if (addr_in == OFF_CTRL_A)
      begin
        start_r <= wdata_in[A_START_BIT];
        conv_en_r <= wdata_in[A_EN_BIT];
        fmt_r <= wdata_in[A_FMT_BIT];
        ext_channel_sel_r <= wdata_in[A_CHAN_LSB +: 4];
      end
      else if (addr_in == OFF_CTRL_B)
      begin
        input_source_sel_r <= wdata_in[B_SRC_LSB +: 4];
        conv_clock_div_sel_r <= wdata_in[B_DIV_LSB +: 3];
      end
      else if (addr_in == OFF_CTRL_C)
      begin
        ref_amp_enable_r <= wdata_in[C_AMP_EN_BIT];
        ref_amp_input_sel_r <= wdata_in[C_AMP_IN_BIT];
        ref_source_sel_r <= wdata_in[C_REF_LSB +: 2];
        ref_amp_gain_sel_r <= wdata_in[C_GAIN_LSB +: 2];
      end
      else if (addr_in == OFF_BANDGAP)
      begin
        bandgap_en_r <= wdata_in[0];
      end
      else if (addr_in == OFF_PIN_FUNC)
      begin
        pin_func_r <= wdata_in[NUM_PINS-1:0];
      end
      else if (addr_in == OFF_PULL_HIGH)
      begin
        pull_high_r <= wdata_in[NUM_PINS-1:0];
      end
      else if (addr_in == OFF_PORT_DIR)
      begin
        port_dir_r <= wdata_in[NUM_PINS-1:0];
      end
      else if (addr_in == OFF_INT_CTRL)
      begin
        int_en_r <= wdata_in[I_EN_BIT];
      end
    end
  end

  // ***********************************************
  // start detection
  // ***********************************************
  logic start_seen_r;
  logic start_req;
  logic start_wr;
  assign start_wr = wr_in && (addr_in == OFF_CTRL_A);
  // R22 falling edge start
  assign start_req = start_seen_r && start_wr && !wdata_in[A_START_BIT];
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      start_seen_r <= 1'b0;
    end
    else if (start_wr)
    begin
      start_seen_r <= !start_r && wdata_in[A_START_BIT] ? 1'b1 :
        (wdata_in[A_START_BIT] && start_seen_r);
    end
  end

  // ***********************************************
  // conversion sequencer
  // ***********************************************
  logic tick;
  logic [3:0] period_cnt_r;
  conv_clk_div #(
    .DIV_W(3)
  ) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_r),
    .run_in(state_r != ST_IDLE),
    .div_sel_in(conv_clock_div_sel_r),
    .tick_out(tick)
  );
  // R18 divided clock drives sequence
  assign done_pulse = (state_r == ST_CONVERT) && tick &&
    (period_cnt_r == 4'(TOTAL_PERIODS - 1));
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ST_IDLE;
      period_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          period_cnt_r <= '0;
          // R15 start begins cycle
          // R22 ignored while busy
          if (start_req && conv_en_r)
          begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE:
        begin
          if (tick)
          begin
            period_cnt_r <= period_cnt_r + 1'b1;
            // R21 four sample periods
            if (period_cnt_r == 4'(SAMPLE_PERIODS - 1))
            begin
              state_r <= ST_CONVERT;
            end
          end
        end
        ST_CONVERT:
        begin
          if (tick)
          begin
            period_cnt_r <= period_cnt_r + 1'b1;
            // R21 sixteen in total
            if (done_pulse)
            begin
              state_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // busy and interrupt flag
  // ***********************************************
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      busy_r <= 1'b0;
    end
    // R16 busy tracks conversion
    else if (done_pulse)
    begin
      busy_r <= 1'b0;
    end
    else if (state_r == ST_IDLE && start_req && conv_en_r)
    begin
      busy_r <= 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_flag_r <= 1'b0;
    end
    // R17 set wins over clear
    else if (done_pulse)
    begin
      irq_flag_r <= 1'b1;
    end
    else if (wr_in && addr_in == OFF_INT_CTRL && !wdata_in[I_FLAG_BIT])
    begin
      irq_flag_r <= 1'b0;
    end
  end

  // ***********************************************
  // routing decode
  // ***********************************************
  function automatic logic is_ext_source(input logic [3:0] src);
    // R13 external source codes
    is_ext_source = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
  endfunction : is_ext_source
  function automatic logic chan_valid(input logic [3:0] ch);
    // R14 channel map
    chan_valid = (ch <= 4'h1) || (ch >= 4'h5 && ch <= 4'h9) || ch == 4'hb;
  endfunction : chan_valid
  ref_route_t ref_nxt;
  in_route_t in_nxt;
  logic [1:0] div_nxt;
  always_comb
  begin
    // R1 R2 reference route
    if (ref_source_sel_r[1])
    begin
      ref_nxt = REF_AMP;
    end
    else if (ref_source_sel_r[0])
    begin
      ref_nxt = REF_EXT_PIN;
    end
    else
    begin
      ref_nxt = REF_SUPPLY;
    end
    // R11 R12 R13 input route
    div_nxt = input_source_sel_r[1:0] - 2'h1;
    if (is_ext_source(input_source_sel_r))
    begin
      in_nxt = chan_valid(ext_channel_sel_r) ? IN_EXT : IN_FLOAT;
      div_nxt = 2'h0;
    end
    else if (input_source_sel_r[3])
    begin
      in_nxt = IN_GND;
      div_nxt = 2'h0;
    end
    else if (input_source_sel_r[2])
    begin
      in_nxt = IN_AMP;
    end
    else
    begin
      in_nxt = IN_SUPPLY;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  always_ff @(posedge clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rdata_out <= '0;
      ref_route_out <= REF_SUPPLY;
      ref_amp_gain_sel_out <= '0;
      ref_amp_enable_out <= 1'b0;
      ref_amp_input_sel_out <= 1'b0;
      bandgap_enable_out <= 1'b0;
      ext_ref_pin_connect_out <= 1'b0;
      in_route_out <= IN_EXT;
      div_factor_out <= '0;
      ext_channel_onehot_out <= '0;
      conv_power_out <= 1'b0;
      sample_out <= 1'b0;
      convert_out <= 1'b0;
      done_out <= 1'b0;
      irq_out <= 1'b0;
      pin_analog_out <= '0;
      pull_high_en_out <= '0;
      pin_dir_in_out <= '0;
    end
    else
    begin
      rdata_out <= '0;
      if (rd_in)
      begin
        if (addr_in == OFF_CTRL_A)
        begin
          rdata_out <= {start_r, busy_r, conv_en_r, fmt_r, ext_channel_sel_r};
        end
        else if (addr_in == OFF_CTRL_B)
        begin
          rdata_out <= {input_source_sel_r, 1'b0, conv_clock_div_sel_r};
        end
        else if (addr_in == OFF_CTRL_C)
        begin
          rdata_out <= {ref_amp_enable_r, 2'b00, ref_amp_input_sel_r,
            ref_source_sel_r, ref_amp_gain_sel_r};
        end
        else if (addr_in == OFF_BANDGAP)
        begin
          rdata_out <= {7'h00, bandgap_en_r};
        end
        else if (addr_in == OFF_PIN_FUNC)
        begin
          rdata_out <= DATA_W'(pin_func_r);
        end
        else if (addr_in == OFF_PULL_HIGH)
        begin
          rdata_out <= DATA_W'(pull_high_r);
        end
        else if (addr_in == OFF_PORT_DIR)
        begin
          rdata_out <= DATA_W'(port_dir_r);
        end
        else if (addr_in == OFF_INT_CTRL)
        begin
          rdata_out <= {6'h00, int_en_r, irq_flag_r};
        end
      end
      ref_route_out <= ref_nxt;
      // R3 gain code
      ref_amp_gain_sel_out <= ref_amp_gain_sel_r;
      // R4 amplifier power
      ref_amp_enable_out <= ref_amp_enable_r;
      // R5 bandgap to amplifier
      ref_amp_input_sel_out <= ref_amp_input_sel_r;
      bandgap_enable_out <= bandgap_en_r;
      // R6 pin off for internal
      ext_ref_pin_connect_out <= (ref_nxt == REF_EXT_PIN);
      in_route_out <= in_nxt;
      div_factor_out <= div_nxt;
      // R12 channels off unless external
      ext_channel_onehot_out <= (in_nxt == IN_EXT) ?
        (16'h0001 << ext_channel_sel_r) : 16'h0000;
      conv_power_out <= conv_en_r;
      sample_out <= (state_r == ST_SAMPLE);
      convert_out <= (state_r == ST_CONVERT);
      done_out <= done_pulse;
      // R17 interrupt when enabled
      irq_out <= irq_flag_r && int_en_r;
      // R8 analog pin function
      pin_analog_out <= pin_func_r;
      // R9 pull-high removed
      pull_high_en_out <= pull_high_r & ~pin_func_r;
      // R10 direction override
      pin_dir_in_out <= port_dir_r | pin_func_r;
    end
  end
endmodule : adc_ctrl
`default_nettype wire

// >>> bench/adc_ctrl_properties.sv
// Purpose: port checks for the converter control block
// Assumes: one clock domain
// Notes: divider and interrupt enable are shadowed from writes;
// sample phase carries one extra cycle of divider start latency
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties #(
  parameter int NUM_PINS = 8
)
(
  // clock, reset, register port, routing outputs
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic [2:0] ref_route_out,
  input wire logic ext_ref_pin_connect_out,
  input wire logic [4:0] in_route_out,
  input wire logic [15:0] ext_channel_onehot_out,
  // converter core
  input wire logic sample_out,
  input wire logic convert_out,
  input wire logic done_out,
  input wire logic irq_out,
  // pins
  input wire logic [NUM_PINS-1:0] pin_analog_out,
  input wire logic [NUM_PINS-1:0] pull_high_en_out,
  input wire logic [NUM_PINS-1:0] pin_dir_in_out
);
  import adc_ctrl_pkg::*;
  logic [2:0] div_r;
  logic ien_r;
  logic [1:0] ph_r;
  logic [11:0] cnt_r;
  // ****************************************
  // shadow state and phase length counter
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_r <= 3'h0;
      ien_r <= 1'b0;
    end
    else if (wr_in && addr_in == OFF_CTRL_B)
      div_r <= wdata_in[2:0];
    else if (wr_in && addr_in == OFF_INT_CTRL)
      ien_r <= wdata_in[I_EN_BIT];
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ph_r <= 2'h0;
      cnt_r <= 12'h0;
    end
    else
    begin
      ph_r <= {sample_out, convert_out};
      cnt_r <= (ph_r == {sample_out, convert_out}) ? cnt_r + 12'h1 : 12'h1;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence s_sample_end;
    $fell(sample_out) ##0 convert_out;
  endsequence
  sequence s_conv_end;
    $fell(convert_out) ##0 !sample_out;
  endsequence
  AST_REF_ONEHOT: assert property ($onehot(ref_route_out))
    else $error("reference route not one-hot");
  AST_EXT_PIN: assert property (
    ext_ref_pin_connect_out |-> ref_route_out == REF_EXT_PIN)
    else $error("pin connected with internal reference");
  AST_IN_ONEHOT: assert property ($onehot(in_route_out))
    else $error("input route not one-hot");
  AST_INT_SRC: assert property (
    in_route_out != IN_EXT |-> ext_channel_onehot_out == 16'h0000)
    else $error("channel connected with internal source");
  AST_PULL: assert property ((pull_high_en_out & pin_analog_out) == '0)
    else $error("pull-high on analog pin");
  AST_DIR: assert property ((pin_analog_out & ~pin_dir_in_out) == '0)
    else $error("analog pin not an input");
  AST_SAMPLE_LEN: assert property (
    s_sample_end |-> cnt_r == (12'h004 << div_r) + 12'h001)
    else $error("sample phase length wrong");
  AST_CONV_LEN: assert property (
    s_conv_end |-> cnt_r == (12'h00c << div_r))
    else $error("convert phase length wrong");
  AST_DONE: assert property (s_conv_end |-> $past(done_out))
    else $error("no done pulse after conversion");
  AST_IRQ: assert property (done_out && ien_r |-> ##[0:1] irq_out)
    else $error("interrupt not raised");
endmodule : adc_ctrl_properties
bind adc_ctrl adc_ctrl_properties #(.NUM_PINS(NUM_PINS)) i_adc_ctrl_properties
(
  .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .ref_route_out(ref_route_out),
  .ext_ref_pin_connect_out(ext_ref_pin_connect_out),
  .in_route_out(in_route_out),
  .ext_channel_onehot_out(ext_channel_onehot_out),
  .sample_out(sample_out), .convert_out(convert_out), .done_out(done_out),
  .irq_out(irq_out), .pin_analog_out(pin_analog_out),
  .pull_high_en_out(pull_high_en_out), .pin_dir_in_out(pin_dir_in_out)
);
`default_nettype wire

// >>> bench/adc_ctrl_test.sv
// Purpose: self-checking bench for the converter control block
// Assumes: read data stands in the cycle after the read strobe
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_test;
  import adc_ctrl_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic [2:0] ref_route_out;
  logic [1:0] gain, div_factor;
  logic amp_en, amp_in, bg_en, pin_conn, pwr, smp, cnv, done_out, irq_out;
  logic [4:0] in_route_out;
  logic [15:0] chan;
  logic [7:0] ana, pull, dir;
  logic [7:0] rb [9] = '{8'h00, 8'hf7, 8'h9f, 8'h01, 8'hff, 8'hff, 8'hff,
    8'h02, 8'h00};
  int n_fail = 0;
  int comparisons = 0;
  always #10 clk_in = ~clk_in;
  adc_ctrl #(.NUM_PINS(8)) i_adc_ctrl
  (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ref_route_out(ref_route_out),
    .ref_amp_gain_sel_out(gain), .ref_amp_enable_out(amp_en),
    .ref_amp_input_sel_out(amp_in), .bandgap_enable_out(bg_en),
    .ext_ref_pin_connect_out(pin_conn), .in_route_out(in_route_out),
    .div_factor_out(div_factor), .ext_channel_onehot_out(chan),
    .conv_power_out(pwr), .sample_out(smp), .convert_out(cnv),
    .done_out(done_out), .irq_out(irq_out), .pin_analog_out(ana),
    .pull_high_en_out(pull), .pin_dir_in_out(dir)
  );
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk({8'h00, rdata_out}, {8'h00, e});
  endtask : rd
  task automatic idle(input int n);
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
  endtask : idle
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    #400_000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    logic [3:0] s;
    logic ext;
    logic [4:0] er;
    logic [1:0] ed;
    int el;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    idle(3);
    chk({13'h0, ref_route_out, in_route_out[2:0]}, 16'h0009);
    for (int i = 0; i < 16; i++)
      rd(4'(i), 8'h00);
    for (int i = 1; i < 9; i++)
    begin
      wr(4'(i), 8'hff);
      rd(4'(i), rb[i]);
    end
    wr(OFF_PIN_FUNC, 8'h0f);
    wr(OFF_PULL_HIGH, 8'hff);
    wr(OFF_PORT_DIR, 8'h30);
    idle(3);
    chk({8'h00, ana}, 16'h000f);
    chk({8'h00, pull}, 16'h00f0);
    chk({8'h00, dir}, 16'h003f);
    chk({15'h0, bg_en}, 16'h0001);
    $display("test registers and pins finished");
    for (int i = 0; i < 16; i++)
    begin
      s = 4'(i);
      wr(OFF_CTRL_C, {s[0], 2'b00, s[1], s});
      idle(3);
      chk({13'h0, ref_route_out}, s[3] ? 16'h4 : s[2] ? 16'h2 : 16'h1);
      chk({15'h0, pin_conn}, {15'h0, s[3:2] == 2'b01});
      chk({14'h0, gain}, {14'h0, s[1:0]});
      chk({14'h0, amp_en, amp_in}, {14'h0, s[0], s[1]});
    end
    $display("test reference finished");
    wr(OFF_CTRL_A, 8'h05);
    for (int i = 0; i < 16; i++)
    begin
      s = 4'(i);
      wr(OFF_CTRL_B, {s, 4'h0});
      idle(3);
      ext = s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11;
      er = ext ? 5'h01 : s[3] ? 5'h08 : s[2] ? 5'h04 : 5'h02;
      ed = (ext || s[3]) ? 2'h0 : 2'(s[1:0] - 2'h1);
      chk({11'h0, in_route_out}, {11'h0, er});
      chk({14'h0, div_factor}, {14'h0, ed});
      chk(chan, ext ? 16'h0020 : 16'h0000);
    end
    wr(OFF_CTRL_B, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      s = 4'(i);
      if (s inside {4'h2, 4'h3, 4'h4, 4'ha})
        continue;
      wr(OFF_CTRL_A, {4'h0, s});
      idle(3);
      chk(chan, s[3:2] == 2'b11 ? 16'h0 : 16'h1 << s);
      chk({11'h0, in_route_out}, s[3:2] == 2'b11 ? 16'h10 : 16'h1);
    end
    $display("test input routing finished");
    for (int d = 0; d < 8; d++)
    begin
      s = 4'(d);
      wr(OFF_CTRL_B, {5'h0, s[2:0]});
      wr(OFF_INT_CTRL, {6'h0, ~s[0], 1'b0});
      wr(OFF_CTRL_A, 8'ha0);
      wr(OFF_CTRL_A, 8'h20);
      el = int'($time);
      rd(OFF_CTRL_A, 8'h60);
      wr(OFF_CTRL_A, 8'ha0);
      wr(OFF_CTRL_A, 8'h20);
      idle(0);
      for (int n = 0; n < 5000 && done_out !== 1'b1; n++)
      begin
        @(posedge clk_in);
        #1;
      end
      el = (int'($time) - el) / 20;
      chk({14'h0, cnv, smp}, 16'h0002);
      chk(16'(el >= (16 << d) + 1 && el <= (16 << d) + 5), 16'h1);
      idle(2);
      chk({15'h0, irq_out}, {15'h0, ~s[0]});
      rd(OFF_CTRL_A, 8'h20);
      rd(OFF_INT_CTRL, {6'h0, ~s[0], 1'b1});
      wr(OFF_INT_CTRL, 8'h00);
      idle(2);
      chk({15'h0, irq_out}, 16'h0000);
    end
    $display("test conversion finished");
    wr(OFF_CTRL_A, 8'h80);
    wr(OFF_CTRL_A, 8'h00);
    idle(3);
    chk({14'h0, smp, pwr}, 16'h0000);
    wr(OFF_CTRL_A, 8'ha0);
    idle(3);
    chk({14'h0, smp, pwr}, 16'h0001);
    rd(OFF_CTRL_A, 8'ha0);
    $display("test start guard finished");
    close_out();
  end
endmodule : adc_ctrl_test
`default_nettype wire
